/* rtl/epr_port.sv */
`timescale 1ns/1ps
module epr_port
   import epr_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   // avalon-mm slave
   input  wire logic [17:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   // base address configuration
   input  wire logic [7:0]  base_addr_cfg_high_i,
   input  wire logic [7:0]  base_addr_cfg_low_i,
   // peripheral pins
   input  wire logic [7:0]  peripheral_data_lines_i,
   output logic      [7:0]  peripheral_data_lines_o,
   output logic             peripheral_data_lines_oe_n_o,
   input  wire logic        busy_pin_i,
   input  wire logic        ack_pin_n_i,
   input  wire logic        paper_error_pin_i,
   input  wire logic        select_pin_i,
   input  wire logic        fault_pin_n_i,
   output logic             strobe_pin_n_o,
   output logic             auto_feed_pin_n_o,
   output logic             init_pin_n_o,
   output logic             select_in_pin_n_o,
   output logic             ack_irq_o
);

   // ----------------------------------------------------------------
   // state types and registers
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      E_IDLE   = 3'b000,
      E_SETUP  = 3'b001,
      E_STROBE = 3'b010,
      E_HOLD   = 3'b011,
      E_RACK   = 3'b100
   } epr_eng_e;

   logic [12:0]  sy1_r;
   logic [12:0]  sy2_r;
   logic [12:0]  sy3_r;
   logic [12:0]  stb_r;
   logic         ack_d_r;
   logic         bus_ack_r;
   logic [31:0]  rdata_r;
   logic [7:0]   pd_out_r;
   logic         tag_r;
   logic [5:0]   ctl_r;
   epr_mode_e    mode_r;
   logic [2:0]   ecr_r;
   logic [2:0]   cfgb_r;
   logic [8:0]   mem_r [FIFO_DEPTH];
   logic [3:0]   wp_r;
   logic [3:0]   rp_r;
   logic [4:0]   cnt_r;
   epr_eng_e     eng_r;
   logic [4:0]   tmr_r;
   logic         irq_r;

   logic         busy_s;
   logic         ack_s;
   logic [7:0]   pd_s;
   logic [15:0]  off;
   logic         req;
   logic         wr_take;
   logic         rd_take;
   logic         full;
   logic         empty;
   logic         dir_in;
   logic         fwd_on;
   logic         rev_on;
   logic         h_push;
   logic         h_pop;
   logic         e_push;
   logic         e_pop;
   logic         push;
   logic         pop;
   logic         flush;
   logic [8:0]   push_dat;
   logic [7:0]   rd_val;

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------
   // host-side FIFO write allowed at offset 0x400 in mode m
   function automatic logic fifo_wr_ok(input epr_mode_e m,
                                       input logic      din);
      fifo_wr_ok = (m == M_COMPAT_FIFO_PORT) || (m == M_TEST) ||
                   ((m == M_ECP) && !din);
   endfunction : fifo_wr_ok

   // ----------------------------------------------------------------
   // pin input synchronisers
   // ----------------------------------------------------------------
   // three stages; a change counts once stage two and three agree
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sy1_r <= 13'h0000;
         sy2_r <= 13'h0000;
         sy3_r <= 13'h0000;
         stb_r <= 13'h0000;
      end
      else
      begin
         sy1_r <= {busy_pin_i, ack_pin_n_i, paper_error_pin_i,
                   select_pin_i, fault_pin_n_i,
                   peripheral_data_lines_i};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         stb_r <= (sy2_r & sy3_r) | (stb_r & (sy2_r | sy3_r));
      end
   end

   assign busy_s = stb_r[12];
   assign ack_s  = stb_r[11];
   assign pd_s   = stb_r[7:0];

   // ----------------------------------------------------------------
   // acknowledge interrupt
   // ----------------------------------------------------------------
   // one-cycle request on each low-to-high ack edge while the ACKEN control bit is set
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ack_d_r <= 1'b1;
         irq_r   <= 1'b0;
      end
      else
      begin
         ack_d_r <= ack_s;
         irq_r   <= ack_s & ~ack_d_r & ctl_r[CTL_ACKEN];
      end
   end

   assign ack_irq_o = irq_r;

   // ----------------------------------------------------------------
   // bus decode and answer
   // ----------------------------------------------------------------
   // offset is relative to the configured base address
   assign off = avs_address_i[17:2] - {base_addr_cfg_high_i,
                                       base_addr_cfg_low_i};
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~bus_ack_r;
   assign wr_take = avs_write_i & bus_ack_r;
   assign rd_take = avs_read_i & bus_ack_r;
   assign avs_readdata_o = rdata_r;

   // read mux; unmapped or mode-hidden offsets read zero
   always_comb
   begin
      rd_val = 8'h00;
      unique case (off)
         OFF_DATA:
            if (mode_r == M_STD || mode_r == M_BIDIR)
               rd_val = pd_s;
         OFF_STAT:
            rd_val = {~busy_s, ack_s, stb_r[10:8],
                      3'b111};
         OFF_CTRL:
            rd_val = {2'b11, ctl_r};
         OFF_FIFO:
            if (mode_r == M_CFG)
               rd_val = CFGA_VAL;
            else if (!empty)
               rd_val = mem_r[rp_r][7:0];
         OFF_CFGB:
            if (mode_r == M_CFG)
               rd_val = {1'b0, irq_r, cfgb_r, 3'b111};
         OFF_ECR:
            rd_val = {mode_r, ecr_r, full, empty};
         default:
            rd_val = 8'h00;
      endcase
   end

   // one wait state: answer in the cycle after the request
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         bus_ack_r <= 1'b0;
         rdata_r   <= 32'h0000_0000;
      end
      else
      begin
         bus_ack_r <= req & ~bus_ack_r;
         if (avs_read_i && !bus_ack_r)
            rdata_r <= {24'h000000, rd_val};
      end
   end

   // ----------------------------------------------------------------
   // control, extended control and config B
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ctl_r  <= CTL_RST;
         mode_r <= M_STD;
         ecr_r  <= ECR_RST;
         cfgb_r <= 3'h0;
      end
      else if (wr_take)
      begin
         if (off == OFF_CTRL)
            ctl_r <= avs_writedata_i[5:0];
         if (off == OFF_ECR)
         begin
            mode_r <= epr_mode_e'(avs_writedata_i[7:5]);
            ecr_r  <= avs_writedata_i[4:2];
         end
         if (off == OFF_CFGB && mode_r == M_CFG)
            cfgb_r <= avs_writedata_i[5:3];
      end
   end

   // ----------------------------------------------------------------
   // direction and engine enables
   // ----------------------------------------------------------------
   assign dir_in = ctl_r[CTL_DIR] &
                   ~((mode_r == M_STD) || (mode_r == M_COMPAT_FIFO_PORT));
   assign fwd_on = (mode_r == M_COMPAT_FIFO_PORT) ||
                   ((mode_r == M_ECP) && !dir_in);
   assign rev_on = (mode_r == M_ECP) && dir_in;

   // ----------------------------------------------------------------
   // shared FIFO
   // ----------------------------------------------------------------
   assign full  = (cnt_r == 5'(FIFO_DEPTH));
   assign empty = (cnt_r == 5'd0);

   // host pushes: tagged address byte at 0, data bytes at 0x400
   assign h_push = wr_take &&
      (((off == OFF_DATA) && (mode_r == M_ECP) && !dir_in) ||
       ((off == OFF_FIFO) && fifo_wr_ok(mode_r, dir_in)));
   assign h_pop  = rd_take && (off == OFF_FIFO) && !empty &&
      ((mode_r == M_TEST) || rev_on);
   assign push   = (h_push | e_push) & ~full;
   assign pop    = h_pop | e_pop;
   assign push_dat = h_push ?
      {off == OFF_DATA, avs_writedata_i[7:0]} :
      {~busy_s, pd_s};
   // going back to a plain port mode discards queued bytes
   assign flush  = wr_take && (off == OFF_ECR) &&
                   (avs_writedata_i[7:6] == 2'b00);

   // one storage behind every FIFO path
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wp_r  <= 4'h0;
         rp_r  <= 4'h0;
         cnt_r <= 5'h00;
      end
      else if (flush)
      begin
         wp_r  <= 4'h0;
         rp_r  <= 4'h0;
         cnt_r <= 5'h00;
      end
      else
      begin
         if (push)
            wp_r <= wp_r + 4'h1;
         if (pop)
            rp_r <= rp_r + 4'h1;
         cnt_r <= cnt_r + 5'(push) - 5'(pop);
      end
   end

   // storage write, no reset needed for data
   always_ff @(posedge clk_sys_i)
   begin
      if (push)
         mem_r[wp_r] <= push_dat;
   end

   // ----------------------------------------------------------------
   // automatic handshake engine
   // ----------------------------------------------------------------
   assign e_pop  = (eng_r == E_IDLE) && fwd_on && !empty &&
                   !busy_s;
   assign e_push = (eng_r == E_IDLE) && rev_on && !ack_s &&
                   !full;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         eng_r <= E_IDLE;
         tmr_r <= 5'h00;
         tag_r <= 1'b0;
      end
      else if (!fwd_on && !rev_on)
         eng_r <= E_IDLE;
      else
      begin
         unique case (eng_r)
            E_IDLE:
               if (e_pop)
               begin
                  tag_r <= mem_r[rp_r][8];
                  tmr_r <= SETUP_CYC;
                  eng_r <= E_SETUP;
               end
               else if (e_push)
                  eng_r <= E_RACK;
            E_SETUP:
               if (tmr_r == 5'h00)
               begin
                  tmr_r <= STROBE_CYC;
                  eng_r <= E_STROBE;
               end
               else
                  tmr_r <= tmr_r - 5'h01;
            E_STROBE:
               if (tmr_r != 5'h00)
                  tmr_r <= tmr_r - 5'h01;
               else if (busy_s)
                  eng_r <= E_HOLD;
            E_HOLD:
               if (!busy_s)
                  eng_r <= E_IDLE;
            E_RACK:
               if (ack_s)
                  eng_r <= E_IDLE;
            default:
               eng_r <= E_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // data latch and output byte
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         pd_out_r <= 8'h00;
      else if (e_pop)
         pd_out_r <= mem_r[rp_r][7:0];
      else if (wr_take && off == OFF_DATA &&
               (mode_r == M_STD || mode_r == M_BIDIR))
         pd_out_r <= avs_writedata_i[7:0];
   end

   // ----------------------------------------------------------------
   // pin outputs
   // ----------------------------------------------------------------
   assign peripheral_data_lines_o      = pd_out_r;
   assign peripheral_data_lines_oe_n_o = dir_in;
   assign select_in_pin_n_o = ~ctl_r[CTL_SELIN];
   assign init_pin_n_o      = ctl_r[CTL_INIT];

   // engine drives strobe only in its E_STROBE state; it drives auto-feed only in ECP mode
   always_comb
   begin
      strobe_pin_n_o = ~(ctl_r[CTL_STB] |
                         (eng_r == E_STROBE));
      if (mode_r == M_ECP)
         auto_feed_pin_n_o = rev_on ? (eng_r == E_RACK)
                                    : ~tag_r;
      else
         auto_feed_pin_n_o = ~ctl_r[CTL_AFD];
   end
endmodule : epr_port

/* rtl/epr_pkg.sv */
package epr_pkg;
   // -----------------------------------------------------------------
   // register indexes (byte address = 4 * index)
   // -----------------------------------------------------------------
   localparam logic [15:0] OFF_DATA = 16'h0000;
   localparam logic [15:0] OFF_STAT = 16'h0001;
   localparam logic [15:0] OFF_CTRL = 16'h0002;
   localparam logic [15:0] OFF_FIFO = 16'h0400;
   localparam logic [15:0] OFF_CFGB = 16'h0401;
   localparam logic [15:0] OFF_ECR  = 16'h0402;

   // -----------------------------------------------------------------
   // modes and fields
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      M_STD   = 3'b000,
      M_BIDIR = 3'b001,
      M_COMPAT_FIFO_PORT = 3'b010,
      M_ECP   = 3'b011,
      M_ENH   = 3'b100,
      M_RSVD  = 3'b101,
      M_TEST  = 3'b110,
      M_CFG   = 3'b111
   } epr_mode_e;

   localparam int CTL_DIR    = 5;
   localparam int CTL_ACKEN  = 4;
   localparam int CTL_SELIN  = 3;
   localparam int CTL_INIT   = 2;
   localparam int CTL_AFD    = 1;
   localparam int CTL_STB    = 0;
   localparam logic [5:0] CTL_RST  = 6'h04;
   localparam logic [2:0] ECR_RST  = 3'h5;
   localparam logic [7:0] CFGA_VAL = 8'h10;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW    = 4;

   // -----------------------------------------------------------------
   // handshake timing
   // -----------------------------------------------------------------
   localparam int CLK_PS      = 25000;
   localparam int SETUP_NS    = 500;
   localparam int STROBE_NS   = 500;
   localparam logic [4:0] SETUP_CYC =
      5'((SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS);
   localparam logic [4:0] STROBE_CYC =
      5'((STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS);
endpackage : epr_pkg

/* tb/epr_port_properties.sv */
`timescale 1ns/1ps
module epr_port_checker
   import epr_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        arst_n_i,
   input wire logic [17:0] avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic [7:0]  base_addr_cfg_high_i,
   input wire logic [7:0]  base_addr_cfg_low_i,
   input wire logic        init_pin_n_o,
   input wire logic        select_in_pin_n_o,
   input wire logic        strobe_pin_n_o,
   input wire logic        ack_irq_o
);
   logic [15:0] idx_w;
   logic        rd_w;
   logic        wr_w;
   // register index and the cycle in which an access completes
   assign idx_w = avs_address_i[17:2]
                  - {base_addr_cfg_high_i, base_addr_cfg_low_i};
   assign rd_w  = avs_read_i & ~avs_waitrequest_o;
   assign wr_w  = avs_write_i & ~avs_waitrequest_o;

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   wait_first_a: assert property ($rose(avs_read_i || avs_write_i)
      |-> avs_waitrequest_o) else $error("no wait state on new request");
   wait_one_a: assert property ((avs_read_i || avs_write_i)
      && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("more than one wait state");
   idle_nowait_a: assert property (!(avs_read_i || avs_write_i)
      |-> !avs_waitrequest_o) else $error("wait raised while idle");
   rdata_upper_a: assert property (rd_w
      |-> avs_readdata_o[31:8] == 24'h0) else $error("upper lanes set");
   stat_ones_a: assert property (rd_w && idx_w == OFF_STAT
      |-> avs_readdata_o[2:0] == 3'h7) else $error("status low bits");
   ctrl_ones_a: assert property (rd_w && idx_w == OFF_CTRL
      |-> avs_readdata_o[7:6] == 2'h3) else $error("control top bits");
   selin_inv_a: assert property (wr_w && idx_w == OFF_CTRL
      |=> select_in_pin_n_o == !$past(avs_writedata_i[3]))
      else $error("select-in pin not inverted");
   init_follow_a: assert property (wr_w && idx_w == OFF_CTRL
      |=> init_pin_n_o == $past(avs_writedata_i[2]))
      else $error("init pin not direct");
   irq_pulse_a: assert property (ack_irq_o |=> !ack_irq_o)
      else $error("interrupt wider than one cycle");

   cover property (wr_w && idx_w == OFF_FIFO);
   cover property (ack_irq_o);
   cover property ($fell(strobe_pin_n_o));
endmodule : epr_port_checker

bind epr_port epr_port_checker u_chk (
   .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .base_addr_cfg_high_i(base_addr_cfg_high_i),
   .base_addr_cfg_low_i(base_addr_cfg_low_i),
   .init_pin_n_o(init_pin_n_o), .select_in_pin_n_o(select_in_pin_n_o),
   .strobe_pin_n_o(strobe_pin_n_o), .ack_irq_o(ack_irq_o));

/* tb/epr_printer_model.sv */
`timescale 1ns/1ps
module epr_printer_model (
   input  wire logic       clk_sys_i,
   input  wire logic       strobe_pin_n_i,
   input  wire logic       auto_feed_pin_n_i,
   input  wire logic       oe_n_i,
   input  wire logic [7:0] data_lines_i,
   input  wire logic       stall_i,
   input  wire logic       park_en_i,
   input  wire logic [7:0] park_val_i,
   output logic            busy_o,
   output logic            ack_n_o,
   output logic [7:0]      data_o
);
   logic [7:0] rx_q[$];
   logic       afd_q[$];
   logic [7:0] rev_q[$];
   logic [7:0] rev_byte;
   logic [7:0] pat = 8'h00;
   logic       sending;
   // undriven lines show a value that moves every cycle
   always @(posedge clk_sys_i) pat <= pat + 8'h53;
   assign data_o = park_en_i ? park_val_i : (sending ? rev_byte : pat);
   // forward: take byte on strobe; reverse: send queued bytes
   initial
   begin
      busy_o  = 1'b0;
      ack_n_o = 1'b1;
      sending = 1'b0;
      forever
      begin
         @(posedge clk_sys_i);
         if (strobe_pin_n_i === 1'b0 && oe_n_i === 1'b0)
         begin
            rx_q.push_back(data_lines_i);
            afd_q.push_back(auto_feed_pin_n_i);
            busy_o <= 1'b1;
            while (strobe_pin_n_i !== 1'b1 || stall_i)
               @(posedge clk_sys_i);
            repeat (3) @(posedge clk_sys_i);
            busy_o  <= 1'b0;
            ack_n_o <= 1'b0;
            repeat (6) @(posedge clk_sys_i);
            ack_n_o <= 1'b1;
         end
         else if (oe_n_i === 1'b1 && rev_q.size() > 0
                  && auto_feed_pin_n_i === 1'b0)
         begin
            rev_byte <= rev_q.pop_front();
            sending  <= 1'b1;
            @(posedge clk_sys_i);
            ack_n_o <= 1'b0;
            while (auto_feed_pin_n_i !== 1'b1) @(posedge clk_sys_i);
            ack_n_o <= 1'b1;
            while (auto_feed_pin_n_i !== 1'b0) @(posedge clk_sys_i);
            sending <= 1'b0;
         end
      end
   end
endmodule : epr_printer_model

/* tb/epr_port_test.sv */
`timescale 1ns/1ps
module epr_port_test
   import epr_pkg::*;
;
   localparam logic [15:0] BASE = 16'h0100;
   logic        clk_sys, arst_n, av_rd, av_wr, av_wait, pd_oe_n;
   logic        busy, ack_n, paper_error_status, sel, fault_n, stb_n, afd_n;
   logic        init_n, select_in_pin_n, irq, stall, park_en;
   logic [17:0] av_addr;
   logic [31:0] av_wdata, av_rdata;
   logic [7:0]  pd_out, pd_in, pm_data, park_val;
   int          fails = 0, check_count = 0, cyc = 0, irq_cnt = 0;

   assign pd_in = pd_oe_n ? pm_data : pd_out;

   epr_port DUT (.clk_sys_i(clk_sys), .arst_n_i(arst_n),
      .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
      .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
      .avs_waitrequest_o(av_wait), .base_addr_cfg_high_i(BASE[15:8]),
      .base_addr_cfg_low_i(BASE[7:0]), .peripheral_data_lines_i(pd_in),
      .peripheral_data_lines_o(pd_out),
      .peripheral_data_lines_oe_n_o(pd_oe_n), .busy_pin_i(busy),
      .ack_pin_n_i(ack_n), .paper_error_pin_i(paper_error_status),
      .select_pin_i(sel), .fault_pin_n_i(fault_n),
      .strobe_pin_n_o(stb_n), .auto_feed_pin_n_o(afd_n),
      .init_pin_n_o(init_n), .select_in_pin_n_o(select_in_pin_n), .ack_irq_o(irq));

   epr_printer_model PRN (.clk_sys_i(clk_sys), .strobe_pin_n_i(stb_n),
      .auto_feed_pin_n_i(afd_n), .oe_n_i(pd_oe_n), .data_lines_i(pd_out),
      .stall_i(stall), .park_en_i(park_en), .park_val_i(park_val),
      .busy_o(busy), .ack_n_o(ack_n), .data_o(pm_data));

   // clock
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // cycle watchdog and interrupt pulse count
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (cyc == 20000)
      begin
         fails++;
         print_verdict();
      end
   end

   task print_verdict;
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one avalon access, held until waitrequest is seen low
   task bus(input logic w, input logic [15:0] off, input logic [7:0] d,
            output logic [7:0] q);
      @(posedge clk_sys);
      av_addr  <= {BASE + off, 2'b00};
      av_rd    <= !w;
      av_wr    <= w;
      av_wdata <= {24'h0, d};
      // waitrequest and read data are judged at the rising edge itself
      @(posedge clk_sys);
      while (av_wait !== 1'b0) @(posedge clk_sys);
      q = av_rdata[7:0];
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask : bus

   task wr(input logic [15:0] off, input logic [7:0] d);
      logic [7:0] t;
      bus(1'b1, off, d, t);
   endtask : wr

   task rdchk(input string nm, input logic [15:0] off, input logic [7:0] e);
      logic [7:0] t;
      bus(1'b0, off, 8'h00, t);
      chk(nm, e, t);
   endtask : rdchk

   task pins(input logic [3:0] e);
      @(negedge clk_sys);
      chk("pins", {4'h0, e}, {4'h0, select_in_pin_n, init_n, afd_n, stb_n});
   endtask : pins

   task t_reset;
      rdchk("ctrl", OFF_CTRL, 8'hc4);
      rdchk("ecr", OFF_ECR, 8'h15);
      pins(4'hf);
   endtask : t_reset

   task t_status;
      paper_error_status  <= 1'b1;
      sel     <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rdchk("status", OFF_STAT, 8'hef);
      paper_error_status  <= 1'b0;
      sel     <= 1'b1;
      fault_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rdchk("status", OFF_STAT, 8'hd7);
   endtask : t_status

   task t_ctrl;
      wr(OFF_CTRL, 8'h0b);
      pins(4'h0);
      rdchk("ctrl", OFF_CTRL, 8'hcb);
      wr(OFF_CTRL, 8'h34);
      pins(4'hf);
      rdchk("ctrl", OFF_CTRL, 8'hf4);
      chk("oe_n", 8'h00, {7'h0, pd_oe_n});
      wr(OFF_CTRL, 8'h04);
   endtask : t_ctrl

   task t_spp;
      wr(OFF_DATA, 8'ha5);
      @(negedge clk_sys);
      chk("pd_out", 8'ha5, pd_out);
      repeat (5) @(posedge clk_sys);
      rdchk("data", OFF_DATA, 8'ha5);
      wr(OFF_ECR, 8'h34);
      park_val <= 8'h3c;
      park_en  <= 1'b1;
      wr(OFF_CTRL, 8'h24);
      repeat (5) @(posedge clk_sys);
      chk("oe_n", 8'h01, {7'h0, pd_oe_n});
      rdchk("data", OFF_DATA, 8'h3c);
      park_en <= 1'b0;
      wr(OFF_CTRL, 8'h04);
      wr(OFF_ECR, 8'h14);
   endtask : t_spp

   task t_compat_fifo_port;
      int n0;
      PRN.rx_q.delete();
      n0 = irq_cnt;
      wr(OFF_CTRL, 8'h14);
      wr(OFF_ECR, 8'h54);
      stall <= 1'b1;
      for (int i = 0; i < 18; i++)
         wr(OFF_FIFO, 8'(8'h10 + i));
      rdchk("ecr full", OFF_ECR, 8'h56);
      stall <= 1'b0;
      while (PRN.rx_q.size() < 17) @(posedge clk_sys);
      repeat (100) @(posedge clk_sys);
      chk("sent", 8'd17, 8'(PRN.rx_q.size()));
      for (int i = 0; i < 17; i++)
         chk("byte", 8'(8'h10 + i), PRN.rx_q[i]);
      rdchk("ecr empty", OFF_ECR, 8'h55);
      chk("irqs", 8'd17, 8'(irq_cnt - n0));
      wr(OFF_CTRL, 8'h04);
   endtask : t_compat_fifo_port

   task t_ecp;
      PRN.rx_q.delete();
      PRN.afd_q.delete();
      wr(OFF_ECR, 8'h74);
      wr(OFF_DATA, 8'h85);
      wr(OFF_FIFO, 8'h22);
      while (PRN.rx_q.size() < 2) @(posedge clk_sys);
      chk("addr byte", 8'h85, PRN.rx_q[0]);
      chk("addr tag", 8'h00, {7'h0, PRN.afd_q[0]});
      chk("data byte", 8'h22, PRN.rx_q[1]);
      chk("data tag", 8'h01, {7'h0, PRN.afd_q[1]});
      // let the last strobe, busy and ack pulse finish before turning round
      repeat (100) @(posedge clk_sys);
   endtask : t_ecp

   task t_rev;
      wr(OFF_CTRL, 8'h24);
      PRN.rev_q.push_back(8'h5a);
      PRN.rev_q.push_back(8'hc3);
      while (PRN.rev_q.size() > 0 || PRN.sending !== 1'b0)
         @(posedge clk_sys);
      repeat (10) @(posedge clk_sys);
      rdchk("rev", OFF_FIFO, 8'h5a);
      rdchk("rev", OFF_FIFO, 8'hc3);
      rdchk("ecr", OFF_ECR, 8'h75);
      wr(OFF_CTRL, 8'h04);
   endtask : t_rev

   task t_cfg;
      // test mode: bytes go in and come back out of the shared storage
      wr(OFF_ECR, 8'hd4);
      wr(OFF_FIFO, 8'h66);
      wr(OFF_FIFO, 8'h99);
      rdchk("test_fifo_port ecr", OFF_ECR, 8'hd4);
      rdchk("test_fifo_port", OFF_FIFO, 8'h66);
      rdchk("test_fifo_port", OFF_FIFO, 8'h99);
      rdchk("test_fifo_port ecr", OFF_ECR, 8'hd5);
      wr(OFF_ECR, 8'hf4);
      rdchk("cfga", OFF_FIFO, 8'h10);
      wr(OFF_FIFO, 8'h55);
      rdchk("cfga", OFF_FIFO, 8'h10);
      rdchk("unmapped", 16'h0003, 8'h00);
      wr(OFF_ECR, 8'h14);
   endtask : t_cfg

   // main sequence
   initial
   begin
      arst_n   = 1'b0;
      av_rd    = 1'b0;
      av_wr    = 1'b0;
      av_addr  = 18'h0;
      av_wdata = 32'h0;
      paper_error_status   = 1'b0;
      sel      = 1'b1;
      fault_n  = 1'b1;
      stall    = 1'b0;
      park_en  = 1'b0;
      park_val = 8'h00;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_reset();
      t_status();
      t_ctrl();
      t_spp();
      t_compat_fifo_port();
      t_ecp();
      t_rev();
      t_cfg();
      print_verdict();
   end
endmodule : epr_port_test
